// File: hdl/pmsc_mode_state_regs.sv
// Purpose: Mode control/status and state control registers
// Assumes: All inputs synchronous to mclk_in; one register port
// Notes:   Standby timer counts whole milliseconds from a prescaler
//
// Contract
// R1 - Test enable gates standby good override
// R2 - Override drives standby good at level
// R3 - First wake disable blocks wake one
// R4 - Second wake disable blocks wake two
// R5 - Deep sleep needs bit, permit, pin
// R6 - Normal status reads state machine normal
// R7 - Write one removes external frequency input
// R8 - Lock status reads internal PLL lock
// R9 - Write one forces OFF state
// R10 - Timer enable resets from OTP strap
// R11 - Window code selects millisecond duration
// R12 - Expiry sets group flag until cleared
// R13 - Reserved bits read zero, writes ignored
// R14 - Reset restores all field defaults
`timescale 1ns/10ps
module pmsc_mode_state_regs #(
   parameter int unsigned CYC_PER_MS = pmsc_pkg::CYCLES_PER_MS
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic [0:0]  reg_index_in,
   input  wire logic        reg_write_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic        otp_pg_test_permit_in,
   input  wire logic        deep_sleep_otp_permit_in,
   input  wire logic        otp_timer_enable_in,
   input  wire logic        normal_state_in,
   input  wire logic        pll_locked_in,
   input  wire logic        standby_pg_in,
   input  wire logic        wake_input_one_in,
   input  wire logic        wake_input_two_in,
   input  wire logic        standby_active_in,
   input  wire logic        timer_flag_clear_in,
   output logic             standby_power_good_out,
   output logic             wake_one_event_out,
   output logic             wake_two_event_out,
   output logic             deep_sleep_request_out,
   output logic             ext_freq_input_disable_out,
   output logic             force_off_command_out,
   output logic             standby_timer_group_flag_out
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [15:0] mode_q;
   logic        ext_dis_q;
   logic        timer_en_q;
   logic [3:0]  window_q;
   logic        force_off_q;
   logic [31:0] pre_q;
   logic [23:0] ms_q;
   logic        flag_q;
   logic [15:0] rdata_q;
   logic [15:0] mode_rd;
   logic [15:0] sm_rd;
   logic [23:0] window_ms;
   logic        wr_mode;
   logic        wr_sm;
   logic        ms_tick;
   logic        expire;
   logic        timer_run;
   logic        pg_test_en;
   logic        pg_test_lvl;
   logic        wake_one_dis;
   logic        wake_two_dis;
   logic        dsm_en;
   logic        pg_override;
   logic [15:0] mode_d;
   logic        ext_dis_d;
   logic        timer_en_d;
   logic [3:0]  window_d;
   logic        force_off_d;
   logic [15:0] rdata_d;
   logic [31:0] pre_d;
   logic [23:0] ms_d;
   logic        flag_d;
   logic [31:0] pre_last;
   logic [23:0] window_last;

   assign wr_mode = ce_in & reg_write_in
                    & (reg_index_in == pmsc_pkg::IDX_MODE);
   assign wr_sm   = ce_in & reg_write_in
                    & (reg_index_in == pmsc_pkg::IDX_SM_CTRL_ONE);

   // ------------------------------------------------------------
   // Read views
   // ------------------------------------------------------------
   // R13 reserved read zero
   // R6 normal status bit
   // R8 lock status bit
   assign mode_rd = {8'h00, pll_locked_in, 1'b0, normal_state_in,
                     mode_q[4:0]};
   assign sm_rd   = {window_q, 1'b0, timer_en_q, 10'h000};
   assign rdata_d = (reg_index_in == pmsc_pkg::IDX_MODE) ? mode_rd
                                                         : sm_rd;

   // ------------------------------------------------------------
   // Mode fields
   // ------------------------------------------------------------
   assign pg_test_en   = mode_q[pmsc_pkg::POS_PG_TEST_EN];
   assign pg_test_lvl  = mode_q[pmsc_pkg::POS_PG_TEST_LVL];
   assign wake_one_dis = mode_q[pmsc_pkg::POS_WAKE_ONE_DIS];
   assign wake_two_dis = mode_q[pmsc_pkg::POS_WAKE_TWO_DIS];
   assign dsm_en       = mode_q[pmsc_pkg::POS_DSM_EN];
   // R1 needs OTP permit
   assign pg_override  = pg_test_en & otp_pg_test_permit_in;

   // ------------------------------------------------------------
   // Standby timer window
   // ------------------------------------------------------------
   // R11 window code table
   always_comb begin
      unique case (window_q)
         4'h0: window_ms = 24'h00_0010;
         4'h1: window_ms = 24'h00_0020;
         4'h2: window_ms = 24'h00_0080;
         4'h3: window_ms = 24'h00_0200;
         4'h4: window_ms = 24'h00_0400;
         4'h5: window_ms = 24'h00_1000;
         4'h6: window_ms = 24'h00_2000;
         4'h7: window_ms = 24'h00_4000;
         4'h8: window_ms = 24'h01_0000;
         4'h9: window_ms = 24'h02_0000;
         4'hA: window_ms = 24'h04_0000;
         4'hB: window_ms = 24'h08_0000;
         4'hC: window_ms = 24'h10_0000;
         4'hD: window_ms = 24'h20_0000;
         4'hE: window_ms = 24'h40_0000;
         4'hF: window_ms = 24'h80_0000;
      endcase
   end

   // ------------------------------------------------------------
   // Timer counters
   // ------------------------------------------------------------
   // Timer restarts whenever standby is left, so no stale count
   assign timer_run = timer_en_q & standby_active_in;
   assign pre_last    = 32'(CYC_PER_MS - 1);
   assign window_last = window_ms - 24'h00_0001;
   assign ms_tick     = timer_run & (pre_q == pre_last);
   assign expire      = ms_tick & (ms_q == window_last);

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   // R13 writable fields only
   assign mode_d      = wr_mode ? {11'h000, reg_wdata_in[4:0]} : mode_q;
   // R7 sticky disable on one
   assign ext_dis_d   = ext_dis_q
                        | (wr_mode & reg_wdata_in[pmsc_pkg::POS_EXT_FREQ_INPUT_DISABLE]);
   assign timer_en_d  = wr_sm ? reg_wdata_in[pmsc_pkg::POS_TIMER_EN]
                              : timer_en_q;
   assign window_d    = wr_sm ? reg_wdata_in[pmsc_pkg::POS_WINDOW_LO +: 4]
                              : window_q;
   // R9 one-cycle force pulse
   assign force_off_d = wr_sm & reg_wdata_in[pmsc_pkg::POS_FORCE_OFF];
   assign pre_d       = (~timer_run | ms_tick) ? 32'h0000_0000
                                               : pre_q + 32'h0000_0001;
   assign ms_d        = (~timer_run | expire) ? 24'h00_0000
                      : ms_tick ? ms_q + 24'h00_0001 : ms_q;
   // R12 set beats clear, so an expiry is never lost
   assign flag_d      = expire | (flag_q & ~timer_flag_clear_in);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      // R14 power-on defaults
      if (rst_in) begin
         mode_q      <= 16'h0000;
         ext_dis_q   <= 1'b0;
         // R10 OTP reset value
         timer_en_q  <= otp_timer_enable_in;
         window_q    <= pmsc_pkg::WINDOW_RESET;
         force_off_q <= 1'b0;
         rdata_q     <= 16'h0000;
      end else if (ce_in) begin
         mode_q      <= mode_d;
         ext_dis_q   <= ext_dis_d;
         timer_en_q  <= timer_en_d;
         window_q    <= window_d;
         force_off_q <= force_off_d;
         rdata_q     <= rdata_d;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pre_q  <= 32'h0000_0000;
         ms_q   <= 24'h00_0000;
         flag_q <= 1'b0;
      end else if (ce_in) begin
         pre_q  <= pre_d;
         ms_q   <= ms_d;
         flag_q <= flag_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata_out = rdata_q;
   // R1 R2 test override
   assign standby_power_good_out =
      pg_override ? pg_test_lvl : standby_pg_in;
   // R3 wake one gate
   assign wake_one_event_out =
      wake_input_one_in & ~wake_one_dis;
   // R4 wake two gate
   assign wake_two_event_out =
      wake_input_two_in & ~wake_two_dis;
   // R5 deep sleep gate
   assign deep_sleep_request_out =
      wake_input_two_in & dsm_en & deep_sleep_otp_permit_in;
   assign ext_freq_input_disable_out   = ext_dis_q;
   assign force_off_command_out        = force_off_q;
   assign standby_timer_group_flag_out = flag_q;
endmodule : pmsc_mode_state_regs

// File: hdl/pmsc_pkg.sv
// Purpose: Constants for the mode and state control register pair
// Assumes: Registers hold printed bits 23..8 as data bits 15..0
// Notes:   Register indices are local choices
package pmsc_pkg;
   // ------------------------------------------------------------
   // Register indices and data width
   // ------------------------------------------------------------
   localparam int unsigned DATA_W           = 16;
   localparam logic [0:0]  IDX_MODE         = 1'h0;
   localparam logic [0:0]  IDX_SM_CTRL_ONE  = 1'h1;

   // ------------------------------------------------------------
   // Field positions (printed bit minus 8)
   // ------------------------------------------------------------
   localparam int unsigned POS_PG_TEST_EN   = 0;
   localparam int unsigned POS_WAKE_ONE_DIS = 1;
   localparam int unsigned POS_WAKE_TWO_DIS = 2;
   localparam int unsigned POS_PG_TEST_LVL  = 3;
   localparam int unsigned POS_DSM_EN       = 4;
   localparam int unsigned POS_NORMAL       = 5;
   localparam int unsigned POS_EXT_FREQ_INPUT_DISABLE  = 6;
   localparam int unsigned POS_PLL_LOCKED   = 7;
   localparam int unsigned POS_FORCE_OFF    = 0;
   localparam int unsigned POS_TIMER_EN     = 10;
   localparam int unsigned POS_WINDOW_LO    = 12;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [3:0]  WINDOW_RESET     = 4'h0;
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned MS_NS            = 1000000;
   localparam int unsigned CLK_NS           = 4;
   localparam int unsigned CYCLES_PER_MS    = MS_NS / CLK_NS;
   localparam int unsigned MS_CNT_W         = 24;
   localparam int unsigned PRE_CNT_W        = 32;
endpackage : pmsc_pkg

// File: testbench/pmsc_monitor.sv
// Purpose: Port checks for the mode and state registers
// Assumes: One clock, synchronous reset
// Notes:   Hidden fields are judged through read data
`timescale 1ns/10ps
module pmsc_monitor (
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        ce_in,
   input wire logic [0:0]  reg_index_in,
   input wire logic        reg_write_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        otp_pg_test_permit_in,
   input wire logic        standby_pg_in,
   input wire logic        standby_power_good_out,
   input wire logic        wake_input_one_in,
   input wire logic        wake_one_event_out,
   input wire logic        wake_input_two_in,
   input wire logic        deep_sleep_request_out,
   input wire logic        force_off_command_out,
   input wire logic        ext_freq_input_disable_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   sequence acc_ctrl;
      ce_in && reg_index_in == 1'h1;
   endsequence
   sequence wr_ctrl;
      acc_ctrl ##0 reg_write_in;
   endsequence
   chk_pg_pass: assert property (
      !otp_pg_test_permit_in |-> standby_power_good_out == standby_pg_in)
      else $error("standby good not passed through");
   chk_wake_one: assert property (
      wake_one_event_out |-> wake_input_one_in) else $error("wake one");
   chk_deep_pin: assert property (
      deep_sleep_request_out |-> wake_input_two_in) else $error("deep");
   chk_ext_set: assert property (
      ce_in && reg_write_in && reg_index_in == 1'h0 && reg_wdata_in[6]
      |=> ext_freq_input_disable_out) else $error("ext not set");
   chk_ext_hold: assert property (
      ext_freq_input_disable_out |=> ext_freq_input_disable_out)
      else $error("ext dropped");
   chk_off_launch: assert property (
      wr_ctrl ##0 reg_wdata_in[0] |=> force_off_command_out)
      else $error("force off missing");
   chk_off_short: assert property (
      force_off_command_out && ce_in && !reg_write_in
      |=> !force_off_command_out) else $error("force off too long");
   chk_ctrl_resv: assert property (
      acc_ctrl |=> reg_rdata_out[9:0] == 10'h000 && !reg_rdata_out[11])
      else $error("ctrl reserved not zero");
   chk_mode_resv: assert property (
      ce_in && reg_index_in == 1'h0
      |=> reg_rdata_out[15:8] == 8'h00 && !reg_rdata_out[6])
      else $error("mode reserved not zero");
endmodule : pmsc_monitor
bind pmsc_mode_state_regs pmsc_monitor mon (.*);

// File: testbench/pmsc_host.sv
// Purpose: Host model issuing register cycles
// Assumes: Caller enters tasks just after a rising edge
// Notes:   Read data is taken mid-cycle after the index edge
`timescale 1ns/10ps
module pmsc_host (
   input  wire logic        mclk_in,
   input  wire logic [15:0] rdata_in,
   output logic      [0:0]  idx_out,
   output logic             wr_out,
   output logic      [15:0] wdata_out
);
   initial begin
      idx_out = 1'h0;
      wr_out = 1'b0;
      wdata_out = 16'h0000;
   end
   task automatic wr(input logic [0:0] i, input logic [15:0] d);
      idx_out <= i;
      wr_out <= 1'b1;
      wdata_out <= d;
      @(posedge mclk_in);
      wr_out <= 1'b0;
      @(posedge mclk_in);
   endtask : wr
   task automatic rd(input logic [0:0] i, output logic [15:0] d);
      idx_out <= i;
      @(posedge mclk_in);
      @(negedge mclk_in);
      d = rdata_in;
      @(posedge mclk_in);
   endtask : rd
endmodule : pmsc_host

// File: testbench/tb.sv
// Purpose: Self-checking bench for the mode and state registers
// Assumes: One millisecond scaled down to 4 cycles
// Notes:   Host model owns the register port
`timescale 1ns/10ps
module tb;
   logic        mclk_in, rst_in, ce_in, reg_write_in, otp_pg_test_permit_in;
   logic [0:0]  reg_index_in;
   logic [15:0] reg_wdata_in, reg_rdata_out, v;
   logic        deep_sleep_otp_permit_in, otp_timer_enable_in;
   logic        normal_state_in, pll_locked_in, standby_pg_in;
   logic        wake_input_one_in, wake_input_two_in, standby_active_in;
   logic        timer_flag_clear_in, standby_power_good_out;
   logic        wake_one_event_out, wake_two_event_out;
   logic        deep_sleep_request_out, ext_freq_input_disable_out;
   logic        force_off_command_out, standby_timer_group_flag_out;
   logic [4:0]  outs;
   int          n_mismatch, check_count, n_off;
   assign outs = {ext_freq_input_disable_out, standby_power_good_out,
      wake_one_event_out, wake_two_event_out, deep_sleep_request_out};
   pmsc_mode_state_regs #(.CYC_PER_MS(4)) dut (.*);
   pmsc_host host (.mclk_in, .rdata_in(reg_rdata_out),
      .idx_out(reg_index_in), .wr_out(reg_write_in), .wdata_out(reg_wdata_in));
   always #2 mclk_in = ~mclk_in;
   always @(negedge mclk_in) if (force_off_command_out === 1'b1) n_off++;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic t_reset;
      host.rd(1'h0, v);
      chk(v, 16'h0000);
      host.rd(1'h1, v);
      chk(v, 16'h0400);
   endtask : t_reset
   task automatic t_mode;
      normal_state_in <= 1'b1;
      pll_locked_in <= 1'b1;
      wake_input_one_in <= 1'b1;
      wake_input_two_in <= 1'b1;
      host.wr(1'h0, 16'h005F);
      chk({11'h000, outs}, 16'h0019);
      host.rd(1'h0, v);
      chk(v, 16'h00BF);
      host.wr(1'h0, 16'h0000);
      chk({11'h000, outs}, 16'h0016);
      host.rd(1'h0, v);
      chk(v, 16'h00A0);
   endtask : t_mode
   task automatic t_permit;
      otp_pg_test_permit_in <= 1'b0;
      deep_sleep_otp_permit_in <= 1'b0;
      standby_pg_in <= 1'b1;
      host.wr(1'h0, 16'h0011);
      chk({11'h000, outs}, 16'h001E);
      otp_pg_test_permit_in <= 1'b1;
      deep_sleep_otp_permit_in <= 1'b1;
      @(posedge mclk_in);
      chk({11'h000, outs}, 16'h0017);
      ce_in <= 1'b0;
      host.wr(1'h0, 16'h0000);
      ce_in <= 1'b1;
      host.rd(1'h0, v);
      chk(v, 16'h00B1);
      chk({11'h000, outs}, 16'h0017);
   endtask : t_permit
   task automatic t_off;
      host.wr(1'h1, 16'h1401);
      chk(16'(n_off), 16'h0001);
      host.rd(1'h1, v);
      chk(v, 16'h1400);
   endtask : t_off
   task automatic t_timer;
      host.wr(1'h1, 16'h0400);
      standby_active_in <= 1'b1;
      repeat (60) @(posedge mclk_in);
      chk({15'h0000, standby_timer_group_flag_out}, 16'h0000);
      repeat (10) @(posedge mclk_in);
      chk({15'h0000, standby_timer_group_flag_out}, 16'h0001);
      timer_flag_clear_in <= 1'b1;
      standby_active_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      timer_flag_clear_in <= 1'b0;
      chk({15'h0000, standby_timer_group_flag_out}, 16'h0000);
      host.wr(1'h1, 16'h0000);
      host.rd(1'h1, v);
      chk(v, 16'h0000);
   endtask : t_timer
   initial begin
      {mclk_in, normal_state_in, pll_locked_in, standby_pg_in} = 4'h0;
      {wake_input_one_in, wake_input_two_in, standby_active_in} = 3'h0;
      timer_flag_clear_in = 1'b0;
      {rst_in, ce_in, otp_pg_test_permit_in} = 3'h7;
      {deep_sleep_otp_permit_in, otp_timer_enable_in} = 2'h3;
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_reset();
      t_mode();
      t_permit();
      t_off();
      t_timer();
      report_and_stop();
   end
   // Whole run is about a hundred cycles; this span leaves wide margin
   initial begin
      #20000;
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb
